// file: rtl/fso_fail_logic.sv
// fso_fail_logic: failure logic driving three low-side fail outputs and the
// fail-safe input monitor, with its registers on an AXI4-Lite slave.
// assumes failure events and MODE come from logic on CLK; the two pin inputs
// are asynchronous and are synchronised here. pads resolve the wires.
//
// Our own choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps

// Contract
// - any failure switches fail outputs on and sets the readable active flag.
// - causes: watchdog failures, level-two overtemperature, supply short, reset clamp.
// - control bit picks first or second watchdog failure as activation cause.
// - outputs go off only when causes are gone and software clears flag.
// - watchdog cause persists until good trigger seen and watchdog status cleared.
// - activation happens for every listed failure regardless of fail-safe mode.
// - all three outputs start together; first output stays statically low.
// - second output blinks at 1.25 Hz with 50 percent duty.
// - third output gives 100 Hz PWM with 20 percent duty.
// - pull-ups: first Init/Normal, second same unless disabled, third Init only.
// - second output pin also serves as the fail-safe input.
// - controller must give a rising edge within each 240 us window.
// - monitoring on after reset; writing one to disable bit stops it.
// - missed edge sets fail-safe-input failure and drives first and third outputs.
// - fail-safe-input failure changes no mode, asserts no reset or interrupt.
// - clearing the fail-safe-input failure needs a fresh rising edge.
// - monitoring runs only in Normal mode.
// - glitches on the fail-safe input are filtered within 1.5 us.
// - test select input on third pin is filtered over 16 us.
// - watchdog reset event sets watchdog failure status used as cause.
// - reset clamp-high detection is recorded in status and is a cause.
module fso_fail_logic #(
   parameter int unsigned BLINK_PER  = fso_pkg::BLINK_PER_CYC,
   parameter int unsigned BLINK_ON   = fso_pkg::BLINK_ON_CYC,
   parameter int unsigned DIM_PER    = fso_pkg::DIM_PER_CYC,
   parameter int unsigned DIM_ON     = fso_pkg::DIM_ON_CYC,
   parameter int unsigned FSI_WINDOW = fso_pkg::FSI_WINDOW_CYC
) (
   input  wire logic                       CLK,
   input  wire logic                       RST,
   // axi4-lite slave
   input  wire logic [fso_pkg::ADDR_W-1:0] S_AXI_AWADDR,
   input  wire logic                       S_AXI_AWVALID,
   output logic                            S_AXI_AWREADY,
   input  wire logic [31:0]                S_AXI_WDATA,
   input  wire logic [3:0]                 S_AXI_WSTRB,
   input  wire logic                       S_AXI_WVALID,
   output logic                            S_AXI_WREADY,
   output logic [1:0]                      S_AXI_BRESP,
   output logic                            S_AXI_BVALID,
   input  wire logic                       S_AXI_BREADY,
   input  wire logic [fso_pkg::ADDR_W-1:0] S_AXI_ARADDR,
   input  wire logic                       S_AXI_ARVALID,
   output logic                            S_AXI_ARREADY,
   output logic [31:0]                     S_AXI_RDATA,
   output logic [1:0]                      S_AXI_RRESP,
   output logic                            S_AXI_RVALID,
   input  wire logic                       S_AXI_RREADY,
   // system side
   input  wire logic [2:0]                 MODE,
   input  wire logic                       WATCHDOG_FAILURE_STATUS_EVT,
   input  wire logic                       WD_TRIG_OK,
   input  wire logic                       THERMAL_SHUTDOWN_LEVEL2,
   input  wire logic                       MAIN_SUPPLY_OUTPUT_SHORT,
   input  wire logic                       RESET_CLAMP_DET,
   // pins
   output logic                            STATIC_FAIL_OUT_O,
   output logic                            STATIC_FAIL_OUT_OE_N,
   output logic                            STATIC_FAIL_OUT_PU_EN,
   input  wire logic                       BLINK_FAIL_OUT_I,
   output logic                            BLINK_FAIL_OUT_O,
   output logic                            BLINK_FAIL_OUT_OE_N,
   output logic                            BLINK_FAIL_OUT_PU_EN,
   input  wire logic                       DIM_FAIL_OUT_I,
   output logic                            DIM_FAIL_OUT_O,
   output logic                            DIM_FAIL_OUT_OE_N,
   output logic                            DIM_FAIL_OUT_PU_EN,
   output logic                            TEST_MODE_SEL
);

   localparam int BW = $clog2(BLINK_PER);
   localparam int DW = $clog2(DIM_PER);
   localparam int WW = $clog2(FSI_WINDOW);
   localparam int FW = $clog2(fso_pkg::FSI_FILT_CYC + 1);
   localparam int TW = $clog2(fso_pkg::TEST_FILT_CYC + 1);

   // axi state
   logic                       aw_hold_q;
   logic [fso_pkg::ADDR_W-1:0] awaddr_q;
   logic                       w_hold_q;
   logic [31:0]                wdata_q;
   logic [3:0]                 wstrb_q;
   logic                       bvalid_q;
   logic [1:0]                 bresp_q;
   logic                       rvalid_q;
   logic [31:0]                rdata_q;
   logic [1:0]                 rresp_q;
   // control and status
   logic                       wd_sel_q;
   logic                       fsi_dis_q;
   logic                       fo_flag_q;
   logic                       fsi_fail_q;
   logic                       fsi_clr_pend_q;
   logic                       clamp_q;
   logic [1:0]                 wd_cnt_q;
   logic                       wd_trig_q;
   // waveform counters
   logic [BW-1:0]              blink_cnt_q;
   logic [DW-1:0]              dim_cnt_q;
   // input conditioning
   logic [1:0]                 fsi_sync_q;
   logic [1:0]                 test_sync_q;
   logic [FW-1:0]              fsi_filt_cnt_q;
   logic                       fsi_filt_q;
   logic                       fsi_filt_prev_q;
   logic [TW-1:0]              test_filt_cnt_q;
   logic                       test_q;
   logic [WW-1:0]              win_cnt_q;
   // pin drive
   logic                       fo1_on_q;
   logic                       fo2_on_q;
   logic                       fo3_on_q;
   logic                       pu1_q;
   logic                       pu2_q;
   logic                       pu3_q;

   logic                       wr_go;
   logic                       wr_ok;
   logic                       wr_ctrl;
   logic                       wr_stat;
   logic                       wr_wd;
   logic                       wd_cause;
   logic                       cause;
   logic                       fo_any;
   logic                       mon_en;
   logic                       fsi_rise;
   logic                       fsi_miss;
   logic                       mode_init;
   logic                       mode_norm;

   // true when an address hits one of the three registers
   function automatic logic addr_hit(input logic [fso_pkg::ADDR_W-1:0] a);
      addr_hit = (a == fso_pkg::ADDR_HARDWARE_CONTROL_REG) || (a == fso_pkg::ADDR_DEVICE_STATUS_REG) ||
                 (a == fso_pkg::ADDR_WD_STAT);
   endfunction

   // ---------------- axi4-lite slave ----------------
   assign S_AXI_AWREADY = !aw_hold_q && !bvalid_q;
   assign S_AXI_WREADY  = !w_hold_q && !bvalid_q;
   assign S_AXI_ARREADY = !rvalid_q;
   assign S_AXI_BVALID  = bvalid_q;
   assign S_AXI_BRESP   = bresp_q;
   assign S_AXI_RVALID  = rvalid_q;
   assign S_AXI_RDATA   = rdata_q;
   assign S_AXI_RRESP   = rresp_q;

   // write commits once both halves are held; lane 0 carries every field
   assign wr_go   = aw_hold_q && w_hold_q && !bvalid_q;
   assign wr_ok   = wr_go && wstrb_q[0];
   assign wr_ctrl = wr_ok && (awaddr_q == fso_pkg::ADDR_HARDWARE_CONTROL_REG);
   assign wr_stat = wr_ok && (awaddr_q == fso_pkg::ADDR_DEVICE_STATUS_REG);
   assign wr_wd   = wr_ok && (awaddr_q == fso_pkg::ADDR_WD_STAT);

   // address and data are taken in either order and held until committed
   always_ff @(posedge CLK) begin
      if (RST) begin
         aw_hold_q <= 1'b0;
         awaddr_q  <= '0;
         w_hold_q  <= 1'b0;
         wdata_q   <= '0;
         wstrb_q   <= '0;
      end else begin
         if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            aw_hold_q <= 1'b1;
            awaddr_q  <= S_AXI_AWADDR;
         end else if (wr_go) begin
            aw_hold_q <= 1'b0;
         end
         if (S_AXI_WVALID && S_AXI_WREADY) begin
            w_hold_q <= 1'b1;
            wdata_q  <= S_AXI_WDATA;
            wstrb_q  <= S_AXI_WSTRB;
         end else if (wr_go) begin
            w_hold_q <= 1'b0;
         end
      end
   end

   // write response; unmapped addresses answer slverr
   always_ff @(posedge CLK) begin
      if (RST) begin
         bvalid_q <= 1'b0;
         bresp_q  <= fso_pkg::RESP_OKAY;
      end else if (wr_go) begin
         bvalid_q <= 1'b1;
         bresp_q  <= addr_hit(awaddr_q) ? fso_pkg::RESP_OKAY : fso_pkg::RESP_SLVERR;
      end else if (S_AXI_BREADY) begin
         bvalid_q <= 1'b0;
      end
   end

   // read channel, one cycle from address to data
   always_ff @(posedge CLK) begin
      if (RST) begin
         rvalid_q <= 1'b0;
         rdata_q  <= '0;
         rresp_q  <= fso_pkg::RESP_OKAY;
      end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
         rvalid_q <= 1'b1;
         rresp_q  <= addr_hit(S_AXI_ARADDR) ? fso_pkg::RESP_OKAY : fso_pkg::RESP_SLVERR;
         case (S_AXI_ARADDR)
            fso_pkg::ADDR_HARDWARE_CONTROL_REG:  rdata_q <= {30'h0, fsi_dis_q, wd_sel_q};
            fso_pkg::ADDR_DEVICE_STATUS_REG: rdata_q <= {28'h0, fo_any, clamp_q, fsi_fail_q,
                                                fo_flag_q};
            fso_pkg::ADDR_WD_STAT:  rdata_q <= {29'h0, wd_trig_q, wd_cnt_q};
            default:                rdata_q <= '0;
         endcase
      end else if (S_AXI_RREADY) begin
         rvalid_q <= 1'b0;
      end
   end

   // ---------------- control register ----------------
   // monitoring enabled after reset until software sets the disable bit
   always_ff @(posedge CLK) begin
      if (RST) begin
         wd_sel_q  <= fso_pkg::HARDWARE_CONTROL_REG_RST[fso_pkg::BIT_WD_SEL];
         fsi_dis_q <= fso_pkg::HARDWARE_CONTROL_REG_RST[fso_pkg::BIT_FSI_DIS];
      end else if (wr_ctrl) begin
         wd_sel_q  <= wdata_q[fso_pkg::BIT_WD_SEL];
         fsi_dis_q <= wdata_q[fso_pkg::BIT_FSI_DIS];
      end
   end

   // ---------------- failure causes ----------------
   assign mode_init = (MODE == fso_pkg::FSO_MODE_INIT);
   assign mode_norm = (MODE == fso_pkg::FSO_MODE_NORMAL);
   // one or two watchdog failures, by control bit
   assign wd_cause  = wd_sel_q ? (wd_cnt_q == 2'h2) : (wd_cnt_q != 2'h0);
   // no mode term: every cause counts, fail-safe entry or not
   assign cause     = wd_cause || THERMAL_SHUTDOWN_LEVEL2 || MAIN_SUPPLY_OUTPUT_SHORT ||
                      clamp_q;

   // watchdog failure count saturates at two; clear needs a good trigger first
   always_ff @(posedge CLK) begin
      if (RST) begin
         wd_cnt_q  <= 2'h0;
         wd_trig_q <= 1'b0;
      end else if (WATCHDOG_FAILURE_STATUS_EVT) begin
         wd_cnt_q  <= (wd_cnt_q == 2'h2) ? 2'h2 : wd_cnt_q + 2'h1;
         wd_trig_q <= 1'b0;
      end else if (wr_wd && wdata_q[fso_pkg::BIT_WD_CLR] && wd_trig_q) begin
         wd_cnt_q  <= 2'h0;
         wd_trig_q <= 1'b0;
      end else if (WD_TRIG_OK && (wd_cnt_q != 2'h0)) begin
         wd_trig_q <= 1'b1;
      end
   end

   // clamp-high is sticky; a new detection beats a clear
   always_ff @(posedge CLK) begin
      if (RST) begin
         clamp_q <= 1'b0;
      end else if (RESET_CLAMP_DET) begin
         clamp_q <= 1'b1;
      end else if (wr_stat && wdata_q[fso_pkg::BIT_CLAMP]) begin
         clamp_q <= 1'b0;
      end
   end

   // active flag; clear has no effect while any cause remains
   always_ff @(posedge CLK) begin
      if (RST) begin
         fo_flag_q <= 1'b0;
      end else if (cause) begin
         fo_flag_q <= 1'b1;
      end else if (wr_stat && wdata_q[fso_pkg::BIT_FO_FLAG]) begin
         fo_flag_q <= 1'b0;
      end
   end

   // ---------------- fail-safe input ----------------
   // the input is the blink pin read back; it passes two flops first
   always_ff @(posedge CLK) begin
      if (RST) begin
         fsi_sync_q  <= 2'h3;
         test_sync_q <= 2'h3;
      end else begin
         fsi_sync_q  <= {fsi_sync_q[0], BLINK_FAIL_OUT_I};
         test_sync_q <= {test_sync_q[0], DIM_FAIL_OUT_I};
      end
   end

   // a level must hold for the full filter time before it is accepted
   always_ff @(posedge CLK) begin
      if (RST) begin
         fsi_filt_cnt_q  <= '0;
         fsi_filt_q      <= 1'b1;
         fsi_filt_prev_q <= 1'b1;
      end else begin
         fsi_filt_prev_q <= fsi_filt_q;
         if (fsi_sync_q[1] == fsi_filt_q) begin
            fsi_filt_cnt_q <= '0;
         end else if (fsi_filt_cnt_q == FW'(fso_pkg::FSI_FILT_CYC - 1)) begin
            fsi_filt_cnt_q <= '0;
            fsi_filt_q     <= fsi_sync_q[1];
         end else begin
            fsi_filt_cnt_q <= fsi_filt_cnt_q + FW'(1);
         end
      end
   end

   // test select uses the longer filter; same scheme
   always_ff @(posedge CLK) begin
      if (RST) begin
         test_filt_cnt_q <= '0;
         test_q          <= 1'b1;
      end else if (test_sync_q[1] == test_q) begin
         test_filt_cnt_q <= '0;
      end else if (test_filt_cnt_q == TW'(fso_pkg::TEST_FILT_CYC - 1)) begin
         test_filt_cnt_q <= '0;
         test_q          <= test_sync_q[1];
      end else begin
         test_filt_cnt_q <= test_filt_cnt_q + TW'(1);
      end
   end

   // outside Normal mode or when disabled the input is ignored
   assign mon_en   = mode_norm && !fsi_dis_q;
   assign fsi_rise = mon_en && fsi_filt_q && !fsi_filt_prev_q;
   assign fsi_miss = mon_en && !fsi_rise && (win_cnt_q == WW'(FSI_WINDOW - 1));

   // window restarts on every accepted rising edge
   always_ff @(posedge CLK) begin
      if (RST) begin
         win_cnt_q <= '0;
      end else if (!mon_en || fsi_rise || fsi_miss) begin
         win_cnt_q <= '0;
      end else begin
         win_cnt_q <= win_cnt_q + WW'(1);
      end
   end

   // failure only touches its flag and outputs: no mode, reset or interrupt
   // path exists from here. a pending clear waits for a fresh edge.
   always_ff @(posedge CLK) begin
      if (RST) begin
         fsi_fail_q     <= 1'b0;
         fsi_clr_pend_q <= 1'b0;
      end else if (fsi_miss) begin
         fsi_fail_q     <= 1'b1;
         fsi_clr_pend_q <= 1'b0;
      end else if (fsi_clr_pend_q && fsi_rise) begin
         fsi_fail_q     <= 1'b0;
         fsi_clr_pend_q <= 1'b0;
      end else if (wr_stat && wdata_q[fso_pkg::BIT_FSI_FAIL] && fsi_fail_q) begin
         fsi_clr_pend_q <= 1'b1;
      end
   end

   // ---------------- waveforms and pins ----------------
   assign fo_any = fo_flag_q || fsi_fail_q;

   // dividers sit at zero while idle, so the first active cycle is already
   // a low phase and all three outputs can switch on at the same edge
   always_ff @(posedge CLK) begin
      if (RST) begin
         blink_cnt_q   <= '0;
         dim_cnt_q     <= '0;
      end else begin
         if (!fo_flag_q || (blink_cnt_q == BW'(BLINK_PER - 1))) begin
            blink_cnt_q <= '0;
         end else begin
            blink_cnt_q <= blink_cnt_q + BW'(1);
         end
         if (!fo_any || (dim_cnt_q == DW'(DIM_PER - 1))) begin
            dim_cnt_q <= '0;
         end else begin
            dim_cnt_q <= dim_cnt_q + DW'(1);
         end
      end
   end

   // switch on means pin pulled low; all start in their on phase together
   always_ff @(posedge CLK) begin
      if (RST) begin
         fo1_on_q <= 1'b0;
         fo2_on_q <= 1'b0;
         fo3_on_q <= 1'b0;
      end else begin
         fo1_on_q <= fo_any;
         fo2_on_q <= fo_flag_q && (blink_cnt_q < BW'(BLINK_ON));
         fo3_on_q <= fo_any && (dim_cnt_q < DW'(DIM_ON));
      end
   end

   // pull-ups by mode, registered to keep pad controls glitch free
   always_ff @(posedge CLK) begin
      if (RST) begin
         pu1_q <= 1'b0;
         pu2_q <= 1'b0;
         pu3_q <= 1'b0;
      end else begin
         pu1_q <= mode_init || mode_norm;
         pu2_q <= (mode_init || mode_norm) && !fsi_dis_q;
         pu3_q <= mode_init;
      end
   end

   // low-side switches only ever drive zero
   assign STATIC_FAIL_OUT_O     = 1'b0;
   assign STATIC_FAIL_OUT_OE_N  = !fo1_on_q;
   assign STATIC_FAIL_OUT_PU_EN = pu1_q;
   assign BLINK_FAIL_OUT_O      = 1'b0;
   assign BLINK_FAIL_OUT_OE_N   = !fo2_on_q;
   assign BLINK_FAIL_OUT_PU_EN  = pu2_q;
   assign DIM_FAIL_OUT_O        = 1'b0;
   assign DIM_FAIL_OUT_OE_N     = !fo3_on_q;
   assign DIM_FAIL_OUT_PU_EN    = pu3_q;
   assign TEST_MODE_SEL         = test_q;

endmodule

// file: rtl/fso_pkg.sv
// fso_pkg: constants, register map and mode codes for the fail output block.
// assumes a single 20 MHz core clock and a 32-bit AXI4-Lite register port.
package fso_pkg;

   // clock
   localparam int unsigned CLK_HZ         = 20_000_000;
   localparam int unsigned CLK_PERIOD_NS  = 50;

   // register map, byte addresses
   localparam int unsigned ADDR_W         = 8;
   localparam logic [7:0]  ADDR_HARDWARE_CONTROL_REG   = 8'h00;
   localparam logic [7:0]  ADDR_DEVICE_STATUS_REG  = 8'h04;
   localparam logic [7:0]  ADDR_WD_STAT   = 8'h08;

   // hardware_control_reg fields
   localparam int unsigned BIT_WD_SEL     = 0;
   localparam int unsigned BIT_FSI_DIS    = 1;
   localparam logic [1:0]  HARDWARE_CONTROL_REG_RST    = 2'h0;

   // device_status_reg fields (write one to clear, except bit 3 which is read only)
   localparam int unsigned BIT_FO_FLAG    = 0;
   localparam int unsigned BIT_FSI_FAIL   = 1;
   localparam int unsigned BIT_CLAMP      = 2;
   localparam int unsigned BIT_FO_LIVE    = 3;

   // watchdog_failure_status fields
   localparam int unsigned BIT_WD_CLR     = 0;
   localparam int unsigned BIT_WD_TRIG    = 2;

   // axi responses
   localparam logic [1:0]  RESP_OKAY      = 2'h0;
   localparam logic [1:0]  RESP_SLVERR    = 2'h2;

   // timing, figures in their own units
   localparam int unsigned FSI_WINDOW_US  = 240;
   localparam int unsigned FSI_FILT_NS    = 1500;
   localparam int unsigned TEST_FILT_NS   = 16000;
   localparam longint unsigned BLINK_FREQ_MHZ = 1250;  // millihertz
   localparam int unsigned BLINK_DUTY_PCT = 50;
   localparam int unsigned DIM_FREQ_HZ    = 100;
   localparam int unsigned DIM_DUTY_PCT   = 20;

   // derived cycle counts; longest times round down
   localparam int unsigned FSI_WINDOW_CYC = FSI_WINDOW_US * (CLK_HZ / 1_000_000);
   localparam int unsigned FSI_FILT_CYC   = FSI_FILT_NS / CLK_PERIOD_NS;
   localparam int unsigned TEST_FILT_CYC  = TEST_FILT_NS / CLK_PERIOD_NS;
   localparam int unsigned BLINK_PER_CYC  =
      int'((longint'(CLK_HZ) * 64'd1000) / BLINK_FREQ_MHZ);
   localparam int unsigned BLINK_ON_CYC   = BLINK_PER_CYC * BLINK_DUTY_PCT / 100;
   localparam int unsigned DIM_PER_CYC    = CLK_HZ / DIM_FREQ_HZ;
   localparam int unsigned DIM_ON_CYC     = DIM_PER_CYC * DIM_DUTY_PCT / 100;

   // operating modes reported by the mode controller
   typedef enum logic [2:0] {
      FSO_MODE_INIT     = 3'b000,
      FSO_MODE_NORMAL   = 3'b001,
      FSO_MODE_STOP     = 3'b010,
      FSO_MODE_SLEEP    = 3'b011,
      FSO_MODE_RESTART  = 3'b100,
      FSO_MODE_FAILSAFE = 3'b101
   } fso_mode_t;

endpackage

// file: test/fso_fail_logic_sva.sv
// fso_fail_logic_sva: port checker for the fail output block.
// assumes the bench sets DIM_ON to 4 cycles; bound to every instance.
`timescale 1ns/1ps
module fso_fail_logic_chk (
   input wire logic       CLK,
   input wire logic       RST,
   input wire logic [2:0] MODE,
   input wire logic       THERMAL_SHUTDOWN_LEVEL2,
   input wire logic       MAIN_SUPPLY_OUTPUT_SHORT,
   input wire logic       STATIC_FAIL_OUT_OE_N,
   input wire logic       STATIC_FAIL_OUT_PU_EN,
   input wire logic       BLINK_FAIL_OUT_OE_N,
   input wire logic       DIM_FAIL_OUT_OE_N,
   input wire logic       DIM_FAIL_OUT_PU_EN,
   input wire logic       S_AXI_AWVALID,
   input wire logic       S_AXI_AWREADY,
   input wire logic       S_AXI_WVALID,
   input wire logic       S_AXI_WREADY,
   input wire logic       S_AXI_BVALID
);
   // one clock domain, so clocking and reset are given once
   default clocking @(posedge CLK); endclocking
   default disable iff (RST);
   a_blink_needs_static: assert property (
      !BLINK_FAIL_OUT_OE_N |-> !STATIC_FAIL_OUT_OE_N) else $error("blink on alone");
   a_dim_needs_static: assert property (
      !DIM_FAIL_OUT_OE_N |-> !STATIC_FAIL_OUT_OE_N) else $error("dim on alone");
   a_pu_static: assert property (!$past(RST) |-> STATIC_FAIL_OUT_PU_EN ==
      ($past(MODE) == fso_pkg::FSO_MODE_INIT || $past(MODE) == fso_pkg::FSO_MODE_NORMAL))
      else $error("static pull-up wrong");
   a_pu_dim: assert property (!$past(RST) |->
      DIM_FAIL_OUT_PU_EN == ($past(MODE) == fso_pkg::FSO_MODE_INIT)) else $error("dim pull-up");
   a_tsd_on: assert property (
      $rose(THERMAL_SHUTDOWN_LEVEL2) |-> ##[1:3] !STATIC_FAIL_OUT_OE_N) else $error("no activation");
   a_short_dim_on: assert property (
      $rose(MAIN_SUPPLY_OUTPUT_SHORT) |-> ##[1:3] !DIM_FAIL_OUT_OE_N) else $error("dim not low");
   a_cause_holds: assert property (
      (THERMAL_SHUTDOWN_LEVEL2 || MAIN_SUPPLY_OUTPUT_SHORT) && !STATIC_FAIL_OUT_OE_N
      |=> !STATIC_FAIL_OUT_OE_N) else $error("released with cause present");
   a_dim_low_phase: assert property (
      $fell(DIM_FAIL_OUT_OE_N) ##1 (!STATIC_FAIL_OUT_OE_N) [*4]
      |-> DIM_FAIL_OUT_OE_N && !$past(DIM_FAIL_OUT_OE_N)) else $error("dim low phase length");
   a_wr_answer: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY
      |=> ##1 S_AXI_BVALID) else $error("write not answered");
endmodule
bind fso_fail_logic fso_fail_logic_chk fso_fail_logic_chk_i (.*);

// file: test/fso_mcu_model.sv
// fso_mcu_model: controller and tester standing at the two shared pins.
// assumes the bench commands their levels; a switched-on output wins the wire.
`timescale 1ns/1ps
module fso_mcu_model (
   input  wire logic fsi_lvl,
   input  wire logic blink_oe_n,
   input  wire logic test_lvl,
   input  wire logic dim_oe_n,
   output logic      blink_pin,
   output logic      dim_pin
);
   // low-side switch pulls down over the push-pull drive (wired and)
   assign blink_pin = fsi_lvl & blink_oe_n;
   assign dim_pin = test_lvl & dim_oe_n;
endmodule

// file: test/tb_top.sv
// tb_top: scenario bench for the fail output block.
// assumes shortened counts: blink 40/20, dim 20/4, window 100 cycles.
`timescale 1ns/1ps
module tb_top;
   logic clk = 0, rst = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [3:0] wstrb = 4'hf;
   logic [31:0] wdata = 32'h0, rdata, rd_v;
   logic [2:0] mode = 3'h0;
   logic [1:0] bresp, rresp, rsp;
   logic wd_evt = 0, wd_ok = 0, tsd = 0, gnd_short = 0, clamp = 0, fsi_lvl = 1, tst_lvl = 1;
   logic awready, wready, bvalid, arready, rvalid, tsel, b_pin, d_pin, s_oe_n, b_oe_n, d_oe_n;
   logic b_pu;
   int fail_count = 0, n_checks = 0, cyc = 0;
   always #25 clk = ~clk;
   fso_fail_logic #(.BLINK_PER(40), .BLINK_ON(20), .DIM_PER(20), .DIM_ON(4), .FSI_WINDOW(100))
   fso_fail_logic_i (.CLK(clk), .RST(rst), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
      .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
      .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
      .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
      .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
      .MODE(mode), .WATCHDOG_FAILURE_STATUS_EVT(wd_evt), .WD_TRIG_OK(wd_ok), .THERMAL_SHUTDOWN_LEVEL2(tsd),
      .MAIN_SUPPLY_OUTPUT_SHORT(gnd_short), .RESET_CLAMP_DET(clamp), .STATIC_FAIL_OUT_O(),
      .STATIC_FAIL_OUT_OE_N(s_oe_n), .STATIC_FAIL_OUT_PU_EN(), .BLINK_FAIL_OUT_I(b_pin),
      .BLINK_FAIL_OUT_O(), .BLINK_FAIL_OUT_OE_N(b_oe_n), .BLINK_FAIL_OUT_PU_EN(b_pu),
      .DIM_FAIL_OUT_I(d_pin), .DIM_FAIL_OUT_O(), .DIM_FAIL_OUT_OE_N(d_oe_n),
      .DIM_FAIL_OUT_PU_EN(), .TEST_MODE_SEL(tsel));
   fso_mcu_model fso_mcu_model_i (.fsi_lvl(fsi_lvl), .blink_oe_n(b_oe_n), .test_lvl(tst_lvl),
      .dim_oe_n(d_oe_n), .blink_pin(b_pin), .dim_pin(d_pin));
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task conclude;
      $display("checks=%0d mismatches=%0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // a hung handshake must still reach the report
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fail_count++;
         conclude();
      end
   end
   task tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // address and data offered together, each dropped once taken
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
      fork
         begin do @(posedge clk); while (!awready); awvalid <= 0; end
         begin do @(posedge clk); while (!wready); wvalid <= 0; end
      join
      while (!bvalid) @(posedge clk);
      bready <= 0;
      rsp = bresp;
   endtask
   task rd(input logic [7:0] a);
      @(posedge clk);
      araddr <= a; arvalid <= 1; rready <= 1;
      do @(posedge clk); while (!arready);
      arvalid <= 0;
      do @(posedge clk); while (!rvalid);
      rready <= 0;
      rd_v = rdata;
      rsp = rresp;
   endtask
   task t_regs;
      rd(8'h00); chk(rd_v, 32'h0);
      wr(8'h00, 32'h2); rd(8'h00); chk(rd_v, 32'h2);
      wstrb <= 4'h0; wr(8'h00, 32'h1); wstrb <= 4'hf; rd(8'h00); chk(rd_v, 32'h2);
      wr(8'h00, 32'h0);
      wr(8'h0c, 32'h1); chk({30'h0, rsp}, {30'h0, fso_pkg::RESP_SLVERR});
      $display("test regs done");
   endtask
   // k picks overtemperature, supply short or reset clamp
   task t_cause(input int k);
      int lo, dl;
      @(posedge clk);
      if (k == 0) tsd <= 1; else if (k == 1) gnd_short <= 1; else clamp <= 1;
      @(posedge clk);
      clamp <= 0;
      tick(3);
      chk({s_oe_n, b_oe_n, d_oe_n}, 32'h0);
      lo = 0; dl = 0;
      repeat (40) begin tick(1); lo += !b_oe_n; dl += !d_oe_n; end
      chk(lo, 20);
      chk(dl, 8);
      rd(8'h04); chk(rd_v & 32'h9, 32'h9);
      wr(8'h04, 32'h5); tick(3); chk(s_oe_n, 0);
      tsd <= 0; gnd_short <= 0;
      wr(8'h04, 32'h1); tick(3); chk({s_oe_n, b_oe_n, d_oe_n}, 32'h7);
      $display("test cause %0d done", k);
   endtask
   task pulse(input logic ok);
      @(posedge clk);
      if (ok) wd_ok <= 1; else wd_evt <= 1;
      @(posedge clk);
      wd_ok <= 0; wd_evt <= 0;
   endtask
   task t_wd(input logic sel);
      wr(8'h00, {31'h0, sel});
      pulse(0); tick(4); chk(s_oe_n, sel);
      if (sel) begin pulse(0); tick(4); chk(s_oe_n, 0); end
      rd(8'h08); chk(rd_v & 32'h3, sel ? 32'h2 : 32'h1);
      wr(8'h04, 32'h1); tick(3); chk(s_oe_n, 0);
      pulse(1); wr(8'h08, 32'h1); wr(8'h04, 32'h1); tick(3); chk(s_oe_n, 1);
      wr(8'h00, 32'h0);
      $display("test watchdog %0d done", sel);
   endtask
   task t_fsi;
      @(posedge clk); mode <= fso_pkg::FSO_MODE_STOP;
      tick(150); chk(s_oe_n, 1);
      mode <= fso_pkg::FSO_MODE_NORMAL;
      tick(2); chk(b_pu, 1);
      tick(160); chk({s_oe_n, b_oe_n, d_oe_n}, 32'h2);
      rd(8'h04); chk(rd_v & 32'hb, 32'ha);
      // a first edge restarts the window so no miss cancels the pending clear
      fsi_lvl <= 0; tick(40); fsi_lvl <= 1; tick(34);
      wr(8'h04, 32'h2); tick(5); rd(8'h04); chk(rd_v & 32'h2, 32'h2);
      fsi_lvl <= 0; tick(40); fsi_lvl <= 1; tick(40);
      rd(8'h04); chk(rd_v & 32'h2, 32'h0);
      wr(8'h00, 32'h2); tick(3); chk(b_pu, 0);
      tick(150); chk(s_oe_n, 1);
      mode <= fso_pkg::FSO_MODE_INIT;
      wr(8'h00, 32'h0);
      $display("test fail-safe input done");
   endtask
   initial begin
      repeat (20) @(posedge clk);
      rst <= 0;
      t_regs();
      for (int k = 0; k < 3; k++) t_cause(k);
      t_wd(0);
      t_wd(1);
      t_fsi();
      tst_lvl <= 0; tick(300); chk(tsel, 1); tick(40); chk(tsel, 0);
      conclude();
   end
endmodule
